/* aat_pkg.sv */
package aat_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_AMB_CTRL = 8'h01;
  localparam logic [7:0] ADDR_PROX_SLOW = 8'h03;
  localparam logic [7:0] ADDR_SENS = 8'h04;
  localparam logic [7:0] ADDR_ADAPT = 8'h05;
  localparam logic [7:0] ADDR_CONTACT = 8'h06;
  // Per-stage window: bit 7 set, field in [5:3], stage in [2:0]
  localparam int STAGE_WIN_BIT = 7;
  localparam logic [15:0] AMB_CTRL_RST = 16'h0000;
  localparam logic [15:0] PROX_SLOW_RST = 16'h0000;
  localparam logic [15:0] SENS_RST = 16'h0000;
  localparam logic [15:0] ADAPT_RST = 16'h0000;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int FP_SKIP_LSB = 12;
  localparam int LP_SKIP_LSB = 14;
  localparam int PUSH_LVL_LSB = 14;
  localparam int POS_SENS_LSB = 0;
  localparam int NEG_SENS_LSB = 4;
  localparam int POS_PEAK_LSB = 8;
  localparam int NEG_PEAK_LSB = 12;

  // Per-stage field selectors
  localparam logic [2:0] FLD_AMBIENT = 3'h0;
  localparam logic [2:0] FLD_OFF_HI = 3'h1;
  localparam logic [2:0] FLD_OFF_LO = 3'h2;
  localparam logic [2:0] FLD_THR_HI = 3'h3;
  localparam logic [2:0] FLD_THR_LO = 3'h4;
  localparam logic [2:0] FLD_AVG_MAX = 3'h5;
  localparam logic [2:0] FLD_AVG_MIN = 3'h6;

  // ****************************************************************
  // Arithmetic constants
  // ****************************************************************
  localparam logic [2:0] FP_SKIP_BASE = 3'h3;
  localparam int PUSH_LVL_SHIFT = 4;
  localparam int AMB_SHIFT = 4;
  localparam int OFF_SHIFT = 3;
  localparam int PEAK_SHIFT = 2;
  localparam logic [7:0] PCT_BASE = 8'h40;
  localparam logic [7:0] PCT_STEP = 8'h0C;
  localparam int NUM_STAGES = 8;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic seeded;
    logic [15:0] ambient;
    logic [15:0] last_push;
    logic [15:0] off_hi;
    logic [15:0] off_lo;
    logic [15:0] thr_hi;
    logic [15:0] thr_lo;
    logic [15:0] avg_max;
    logic [15:0] avg_min;
  } aat_stage_t;

  typedef struct packed {
    logic valid;
    logic [2:0] stage;
    logic [15:0] data;
  } aat_sample_t;

  typedef enum logic [0:0] {
    AAT_IDLE = 1'b0,
    AAT_CALC = 1'b1
  } aat_state_t;

  localparam aat_stage_t STAGE_RST = '{
    seeded: 1'b0, ambient: 16'h0000, last_push: 16'h0000,
    off_hi: 16'h0000, off_lo: 16'h0000, thr_hi: 16'hFFFF,
    thr_lo: 16'h0000, avg_max: 16'h0000, avg_min: 16'h0000};

endpackage

/* aat_stage_ram.sv */
`timescale 1ns/1ns
module aat_stage_ram
  import aat_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_wr,
  input wire logic [2:0] i_wr_addr,
  input wire aat_stage_t i_wr_data,
  input wire logic [2:0] i_rd_a_addr,
  output aat_stage_t o_rd_a_data,
  input wire logic [2:0] i_rd_b_addr,
  output aat_stage_t o_rd_b_data
);

  aat_stage_t mem [NUM_STAGES];

  // ****************************************************************
  // Calibration bank, one word per stage, registered reads
  // ****************************************************************
  // Reset loads STAGE_RST into every word so no stage starts with stale thresholds
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      for (int i = 0; i < NUM_STAGES; i++)
      begin
        mem[i] <= STAGE_RST;
      end
      o_rd_a_data <= STAGE_RST;
      o_rd_b_data <= STAGE_RST;
    end
    else
    begin
      if (i_wr)
      begin
        mem[i_wr_addr] <= i_wr_data;
      end
      o_rd_a_data <= mem[i_rd_a_addr];
      o_rd_b_data <= mem[i_rd_b_addr];
    end
  end

endmodule // aat_stage_ram

/* aat_calib.sv */
`timescale 1ns/1ns
module aat_calib
  import aat_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire aat_sample_t i_sample,
  output logic o_sample_ready,
  input wire logic [7:0] i_proximity,
  input wire logic i_low_power,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output logic [7:0] o_contact,
  output logic o_ambient_push
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Sensitivity code to fraction: 64/256 plus 12/256 per step
  function automatic logic [15:0] pct(input logic [3:0] code,
                                     input logic [15:0] val);
    logic [7:0] k;
    logic [23:0] p;
    k = PCT_BASE + PCT_STEP * {4'h0, code};
    p = val * k;
    return p[23:8];
  endfunction

  function automatic logic [15:0] absdiff(input logic [15:0] a,
                                         input logic [15:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  // ****************************************************************
  // Global registers
  // ****************************************************************
  logic [15:0] amb_ctrl;
  logic [15:0] prox_slow;
  logic [15:0] sens;
  logic [15:0] adapt;
  wire logic glob_wr = i_reg_wr && !i_reg_addr[STAGE_WIN_BIT];

  // Software-written configuration, all fields kept as written
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      amb_ctrl <= AMB_CTRL_RST;
      prox_slow <= PROX_SLOW_RST;
      sens <= SENS_RST;
      adapt <= ADAPT_RST;
    end
    else if (glob_wr)
    begin
      if (i_reg_addr == ADDR_AMB_CTRL) amb_ctrl <= i_reg_wdata;
      if (i_reg_addr == ADDR_PROX_SLOW) prox_slow <= i_reg_wdata;
      if (i_reg_addr == ADDR_SENS) sens <= i_reg_wdata;
      if (i_reg_addr == ADDR_ADAPT) adapt <= i_reg_wdata;
    end
  end

  wire logic [1:0] fp_skip = amb_ctrl[FP_SKIP_LSB +: 2];
  wire logic [1:0] lp_skip = amb_ctrl[LP_SKIP_LSB +: 2];
  wire logic [1:0] push_lvl = prox_slow[PUSH_LVL_LSB +: 2];
  wire logic [3:0] pos_sens = sens[POS_SENS_LSB +: 4];
  wire logic [3:0] neg_sens = sens[NEG_SENS_LSB +: 4];
  wire logic [3:0] pos_peak = sens[POS_PEAK_LSB +: 4];
  wire logic [3:0] neg_peak = sens[NEG_PEAK_LSB +: 4];
  wire logic adapt_en = adapt[0];

  // ****************************************************************
  // Pending host offset write and sequencer
  // ****************************************************************
  logic hw_pend;
  logic [2:0] hw_stage;
  logic [2:0] hw_fld;
  logic [15:0] hw_data;
  aat_state_t state;
  logic op_host;
  aat_sample_t smp;
  wire logic stage_wr = i_reg_wr && i_reg_addr[STAGE_WIN_BIT];
  wire logic start_host = (state == AAT_IDLE) && hw_pend;

  // Host writes wait for an idle cycle so calibration never races them
  assign o_sample_ready = (state == AAT_IDLE) && !hw_pend;
  wire logic take_smp = i_sample.valid && o_sample_ready;

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      hw_pend <= 1'b0;
      hw_stage <= 3'h0;
      hw_fld <= 3'h0;
      hw_data <= 16'h0000;
    end
    else if (stage_wr)
    begin
      hw_pend <= 1'b1;
      hw_stage <= i_reg_addr[2:0];
      hw_fld <= i_reg_addr[5:3];
      hw_data <= i_reg_wdata;
    end
    else if (start_host)
    begin
      hw_pend <= 1'b0;
    end
  end

  // Two-step read-modify-write of one stage word
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state <= AAT_IDLE;
      op_host <= 1'b0;
      smp <= '0;
    end
    else
    begin
      case (state)
        AAT_IDLE:
        begin
          if (start_host || take_smp)
          begin
            state <= AAT_CALC;
          end
          op_host <= start_host;
          if (take_smp) smp <= i_sample;
        end
        AAT_CALC: state <= AAT_IDLE;
        default: state <= AAT_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Slow filter skip
  // ****************************************************************
  // Skip count per power mode; counted once per sequence at stage 0
  logic [2:0] seq_cnt;
  logic take_seq;
  wire logic [2:0] skip_n = i_low_power ? {1'b0, lp_skip}
                                        : {1'b0, fp_skip} + FP_SKIP_BASE;

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      seq_cnt <= 3'h0;
      take_seq <= 1'b0;
    end
    else if (take_smp && i_sample.stage == 3'h0)
    begin
      take_seq <= (seq_cnt == 3'h0);
      seq_cnt <= (seq_cnt >= skip_n) ? 3'h0 : seq_cnt + 3'h1;
    end
  end

  // ****************************************************************
  // Calibration bank
  // ****************************************************************
  aat_stage_t cur;
  aat_stage_t nx;
  aat_stage_t rd_b;
  logic [2:0] rd_fld;
  logic rd_pend;
  wire logic calc = (state == AAT_CALC);
  wire logic [2:0] wr_stage = op_host ? hw_stage : smp.stage;
  wire logic [2:0] a_addr = hw_pend ? hw_stage : i_sample.stage;

  aat_stage_ram u_bank3 (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_wr(calc),
    .i_wr_addr(wr_stage),
    .i_wr_data(nx),
    .i_rd_a_addr(a_addr),
    .o_rd_a_data(cur),
    .i_rd_b_addr(i_reg_addr[2:0]),
    .o_rd_b_data(rd_b)
  );

  // ****************************************************************
  // Calibration arithmetic
  // ****************************************************************
  wire logic [15:0] d = smp.data;
  wire logic smp_op = calc && !op_host;
  // Unseeded stage never reports contact; first sample seeds ambient
  wire logic contact = cur.seeded && (d > cur.thr_hi || d < cur.thr_lo);
  wire logic [15:0] lvl = {12'h000, push_lvl, 2'b00} << 2;
  wire logic push = smp_op && cur.seeded && take_seq && !contact
    && !i_proximity[smp.stage]
    && absdiff(d, cur.last_push) > lvl;
  wire logic signed [16:0] amb_diff = {1'b0, d} - {1'b0, cur.ambient};
  // IIR stands in for the FIFO average: no per-entry storage needed
  // Shift kept apart so the mux cannot turn it into a logical shift
  wire logic signed [16:0] amb_step = amb_diff >>> AMB_SHIFT;
  wire logic [16:0] drift = push ? amb_step : 17'h00000;
  wire logic [16:0] off_adj = $signed(drift) >>> OFF_SHIFT;
  wire logic [15:0] amb_new = cur.seeded ? cur.ambient + drift[15:0]
                                         : d;
  wire logic [15:0] resp_pos = (d > amb_new) ? d - amb_new : 16'h0000;
  wire logic [15:0] resp_neg = (d < amb_new) ? amb_new - d : 16'h0000;
  wire logic near_max = resp_pos != 16'h0000
    && resp_pos >= cur.avg_max - pct(pos_peak, cur.avg_max);
  wire logic near_min = resp_neg != 16'h0000
    && resp_neg >= cur.avg_min - pct(neg_peak, cur.avg_min);
  wire logic [16:0] max_err = {1'b0, resp_pos} - {1'b0, cur.avg_max};
  wire logic [16:0] min_err = {1'b0, resp_neg} - {1'b0, cur.avg_min};
  wire logic [16:0] max_step = $signed(max_err) >>> PEAK_SHIFT;
  wire logic [16:0] min_step = $signed(min_err) >>> PEAK_SHIFT;

  // Next stage word; host op replaces one offset, sample op tracks
  always_comb
  begin
    nx = cur;
    if (op_host)
    begin
      if (hw_fld == FLD_OFF_HI) nx.off_hi = hw_data;
      if (hw_fld == FLD_OFF_LO) nx.off_lo = hw_data;
    end
    else
    begin
      nx.seeded = 1'b1;
      nx.ambient = amb_new;
      if (push || !cur.seeded) nx.last_push = d;
      nx.off_hi = cur.off_hi + off_adj[15:0];
      nx.off_lo = cur.off_lo + off_adj[15:0];
      if (near_max && smp_op) nx.avg_max = cur.avg_max + max_step[15:0];
      if (near_min && smp_op) nx.avg_min = cur.avg_min + min_step[15:0];
    end
    // Rescaled on every update, so offset or average changes take hold
    if (adapt_en)
    begin
      nx.thr_hi = nx.ambient + pct(pos_sens, nx.avg_max);
      nx.thr_lo = nx.ambient - pct(neg_sens, nx.avg_min);
    end
    else
    begin
      nx.thr_hi = nx.ambient + pct(pos_sens, nx.off_hi);
      nx.thr_lo = nx.ambient - pct(neg_sens, nx.off_lo);
    end
  end

  // ****************************************************************
  // Outputs and register reads
  // ****************************************************************
  logic [15:0] stage_rd;
  always_comb
  begin
    case (rd_fld)
      FLD_AMBIENT: stage_rd = rd_b.ambient;
      FLD_OFF_HI: stage_rd = rd_b.off_hi;
      FLD_OFF_LO: stage_rd = rd_b.off_lo;
      FLD_THR_HI: stage_rd = rd_b.thr_hi;
      FLD_THR_LO: stage_rd = rd_b.thr_lo;
      FLD_AVG_MAX: stage_rd = rd_b.avg_max;
      FLD_AVG_MIN: stage_rd = rd_b.avg_min;
      default: stage_rd = 16'h0000;
    endcase
  end

  logic [15:0] glob_rd;
  always_comb
  begin
    case (i_reg_addr)
      ADDR_AMB_CTRL: glob_rd = amb_ctrl;
      ADDR_PROX_SLOW: glob_rd = prox_slow;
      ADDR_SENS: glob_rd = sens;
      ADDR_ADAPT: glob_rd = adapt;
      ADDR_CONTACT: glob_rd = {8'h00, o_contact};
      default: glob_rd = 16'h0000;
    endcase
  end

  // Stage reads take two cycles because the bank read is registered
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_reg_rdata <= 16'h0000;
      o_reg_rvalid <= 1'b0;
      rd_pend <= 1'b0;
      rd_fld <= 3'h0;
    end
    else
    begin
      rd_pend <= i_reg_rd && i_reg_addr[STAGE_WIN_BIT];
      rd_fld <= i_reg_addr[5:3];
      o_reg_rvalid <= rd_pend || (i_reg_rd && !i_reg_addr[STAGE_WIN_BIT]);
      if (rd_pend) o_reg_rdata <= stage_rd;
      else if (i_reg_rd) o_reg_rdata <= glob_rd;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_contact <= 8'h00;
      o_ambient_push <= 1'b0;
    end
    else
    begin
      o_ambient_push <= push;
      if (smp_op) o_contact[smp.stage] <= contact;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_prox_freeze;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (smp_op && cur.seeded && i_proximity[smp.stage])
      |-> nx.ambient == cur.ambient;
  endproperty
  a_prox_freeze: assert property (p_prox_freeze)
    else $error("ambient moved during proximity");

  property p_push_level;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (smp_op && absdiff(d, cur.last_push) <= lvl)
      |=> !o_ambient_push;
  endproperty
  a_push_level: assert property (p_push_level)
    else $error("push below update level");

  property p_host_thr;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (calc && op_host && hw_fld == FLD_OFF_HI && !adapt_en)
      |-> nx.thr_hi == cur.ambient + pct(pos_sens, hw_data);
  endproperty
  a_host_thr: assert property (p_host_thr)
    else $error("threshold not rebuilt from new offset");

  property p_mid_code;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (calc && adapt_en && pos_sens == 4'h8)
      |-> nx.thr_hi == nx.ambient
        + 16'((32'(nx.avg_max) * 32'd160) >> 8);
  endproperty
  a_mid_code: assert property (p_mid_code)
    else $error("code 1000 not at 62.5 percent");

  property p_one_rmw;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    take_smp |=> calc ##1 (state == AAT_IDLE);
  endproperty
  a_one_rmw: assert property (p_one_rmw)
    else $error("sample update not a single write");

  property p_contact_flag;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    smp_op |=> o_contact[$past(smp.stage)] == $past(contact);
  endproperty
  a_contact_flag: assert property (p_contact_flag)
    else $error("contact flag mismatch");

  property p_max_gate;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (smp_op && !near_max) |-> nx.avg_max == cur.avg_max;
  endproperty
  a_max_gate: assert property (p_max_gate)
    else $error("maximum moved away from peak");

  property p_skip_field;
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (glob_wr && i_reg_addr == ADDR_AMB_CTRL)
      |=> fp_skip == $past(i_reg_wdata[13:12])
        && lp_skip == $past(i_reg_wdata[15:14]);
  endproperty
  a_skip_field: assert property (p_skip_field)
    else $error("skip fields misplaced");

endmodule // aat_calib

/* aat_host_model.sv */
`timescale 1ns/1ns
module aat_host_model
  import aat_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reg_rvalid,
  input wire logic [15:0] i_reg_rdata,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_addr,
  output logic [15:0] o_reg_wdata
);
  // ****************************************************************
  // Host register master
  // ****************************************************************
  // Bus idles with strobes low and scrambled address and data
  initial
  begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 8'hA5;
    o_reg_wdata = 16'h5A5A;
  end

  // Entered just after an edge; three idle cycles follow so that a
  // stage write has landed before anything else is asked
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
  begin
    o_reg_wr = 1'b1;
    o_reg_addr = a;
    o_reg_wdata = d;
    @(posedge i_core_clk);
    #1 o_reg_wr = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
    repeat (3) @(posedge i_core_clk);
    #1;
  end
  endtask

  // Waits a bounded time; a missing answer comes back unknown
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    int n;
  begin
    d = 16'hXXXX;
    o_reg_rd = 1'b1;
    o_reg_addr = a;
    @(posedge i_core_clk);
    #1 o_reg_rd = 1'b0;
    o_reg_addr = ~a;
    for (n = 0; n < 4; n++)
    begin
      @(posedge i_core_clk);
      if (i_reg_rvalid === 1'b1)
      begin
        d = i_reg_rdata;
        n = 4;
      end
    end
    #1;
  end
  endtask
endmodule // aat_host_model

/* ambient_adaptive_threshold_tb.sv */
`timescale 1ns/1ns
module ambient_adaptive_threshold_tb;
  import aat_pkg::*;
  logic i_core_clk;
  logic i_reset_n;
  aat_sample_t smp;
  logic [7:0] prox;
  logic low_pwr;
  logic reg_wr;
  logic reg_rd;
  logic rvalid;
  logic ready;
  logic push;
  logic [7:0] reg_addr;
  logic [7:0] contact;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] v;
  logic [15:0] amb;
  logic [15:0] hi;
  logic [15:0] lo;
  logic [15:0] p;
  logic [15:0] a1;
  integer seed;
  integer failures;
  integer cmp_count;
  integer push_cnt;
  integer k;

  aat_calib u_aat_calib (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_sample(smp), .o_sample_ready(ready), .i_proximity(prox),
    .i_low_power(low_pwr), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(reg_addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .o_contact(contact), .o_ambient_push(push));

  aat_host_model u_aat_host_model (.i_core_clk(i_core_clk),
    .i_reg_rvalid(rvalid), .i_reg_rdata(rdata), .o_reg_wr(reg_wr),
    .o_reg_rd(reg_rd), .o_reg_addr(reg_addr), .o_reg_wdata(wdata));

  // ****************************************************************
  // Clock, monitor and helpers
  // ****************************************************************
  initial
  begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  // Push pulses are one cycle wide, so count them at every edge
  always @(posedge i_core_clk)
  begin
    if (push === 1'b1)
      push_cnt = push_cnt + 1;
  end

  task automatic check(input string nm, input logic [15:0] s, e);
  begin
    cmp_count = cmp_count + 1;
    if (s !== e)
    begin
      failures = failures + 1;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  end
  endtask

  task automatic test_done();
  begin
    if (failures == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask

  function automatic logic [15:0] pct(input logic [3:0] c, logic [15:0] x);
    logic [31:0] t;
  begin
    t = {16'h0000, x} * (32'(PCT_BASE) + 32'(PCT_STEP) * c);
    return t[23:8];
  end
  endfunction

  function automatic logic [7:0] sa(input logic [2:0] f);
    return {2'b10, f, 3'h0};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_aat_host_model.wr(a, d);
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    u_aat_host_model.rd(a, d);
  endtask

  // Stage 0 sample held until taken or for at most 20 edges, then result given time to land
  task automatic send(input logic [15:0] d);
    int n;
  begin
    smp.valid = 1'b1;
    smp.stage = 3'h0;
    smp.data = d;
    for (n = 0; n < 20; n++)
    begin
      @(posedge i_core_clk);
      if (ready === 1'b1)
        n = 20;
    end
    #1 smp.valid = 1'b0;
    smp.data = ~d;
    repeat (3) @(posedge i_core_clk);
    #1;
  end
  endtask

  // Eight samples cycling through three levels around the ambient
  task automatic burst();
  begin
    for (k = 0; k < 8; k++)
      send(amb - 16'd40 + 16'd40 * 16'(k % 3));
  end
  endtask

  initial
  begin
    #100000;
    failures = failures + 1;
    test_done();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    seed = 96;
    failures = 0;
    cmp_count = 0;
    push_cnt = 0;
    smp = '0;
    prox = 8'h00;
    low_pwr = 1'b0;
    i_reset_n = 1'b0;
    repeat (6) @(posedge i_core_clk);
    #1 i_reset_n = 1'b1;
    rd(ADDR_AMB_CTRL, v);
    check("amb_ctrl_rst", v, AMB_CTRL_RST);
    rd(ADDR_PROX_SLOW, v);
    check("prox_slow_rst", v, PROX_SLOW_RST);
    k = $random(seed);
    rd({2'b10, FLD_THR_HI, 3'(k)}, v);
    check("thr_hi_rst", v, 16'hFFFF);
    repeat (4)
    begin
      hi = 16'($random(seed));
      wr(ADDR_AMB_CTRL, hi);
      rd(ADDR_AMB_CTRL, v);
      check("skip_fields", v & 16'hF000, hi & 16'hF000);
      wr(ADDR_PROX_SLOW, hi);
      rd(ADDR_PROX_SLOW, v);
      check("push_level", v & 16'hC000, hi & 16'hC000);
    end
    // Low power, no skips, push level one, proximity held for now
    low_pwr = 1'b1;
    prox = 8'h01;
    wr(ADDR_AMB_CTRL, 16'h0000);
    wr(ADDR_PROX_SLOW, 16'h4000);
    wr(ADDR_SENS, 16'h0038);
    wr(ADDR_ADAPT, 16'h0000);
    hi = 16'h0100 + (16'($random(seed)) & 16'h00FF);
    lo = 16'h0100 + (16'($random(seed)) & 16'h00FF);
    wr(sa(FLD_OFF_HI), hi);
    wr(sa(FLD_OFF_LO), lo);
    amb = 16'h4000 + (16'($random(seed)) & 16'h0FFF);
    send(amb);
    rd(sa(FLD_AMBIENT), v);
    check("ambient_seed", v, amb);
    rd(sa(FLD_THR_LO), v);
    check("thr_lo", v, amb - pct(4'h3, lo));
    hi = hi + 16'h0010;
    wr(sa(FLD_OFF_HI), hi);
    rd(sa(FLD_THR_HI), v);
    p = pct(4'h8, hi);
    check("thr_hi", v, amb + p);
    // Exactly on the threshold is not yet a contact
    send(amb + p);
    check("contact_eq", {15'h0, contact[0]}, 16'h0000);
    send(amb + p + 16'h0001);
    check("contact_on", {15'h0, contact[0]}, 16'h0001);
    rd(ADDR_CONTACT, v);
    check("contact_reg", v, 16'h0001);
    a1 = p >> 2;
    a1 = a1 + ((p + 16'h0001 - a1) >> 2);
    rd(sa(FLD_AVG_MAX), v);
    check("avg_max", v, a1);
    send(amb);
    check("contact_off", {15'h0, contact[0]}, 16'h0000);
    check("prox_hold", 16'(push_cnt), 16'h0000);
    prox = 8'h00;
    send(amb + 16'h0010);
    check("push_at_level", 16'(push_cnt), 16'h0000);
    send(amb + 16'h0011);
    check("push_above", 16'(push_cnt), 16'h0001);
    amb = amb + 16'h0001;
    rd(sa(FLD_AMBIENT), v);
    check("ambient_track", v, amb);
    send(amb + 16'h0080);
    amb = amb + 16'h0008;
    rd(sa(FLD_OFF_HI), v);
    check("off_hi_drift", v, hi + 16'h0001);
    rd(sa(FLD_THR_HI), v);
    check("thr_hi_drift", v, amb + pct(4'h8, hi + 16'h0001));
    // Full power skips three sequences of every four
    low_pwr = 1'b0;
    push_cnt = 0;
    burst();
    check("fp_pushes", 16'(push_cnt), 16'h0002);
    low_pwr = 1'b1;
    push_cnt = 0;
    burst();
    check("lp_pushes", 16'(push_cnt), 16'h0008);
    // Adaptive mode scales from the tracked maximum
    rd(sa(FLD_AMBIENT), amb);
    rd(sa(FLD_AVG_MAX), a1);
    rd(sa(FLD_OFF_HI), hi);
    wr(ADDR_ADAPT, 16'h0001);
    wr(sa(FLD_OFF_HI), hi);
    rd(sa(FLD_THR_HI), v);
    check("thr_adaptive", v, amb + pct(4'h8, a1));
    test_done();
  end
endmodule // ambient_adaptive_threshold_tb
